// File: core/vtrc_top.sv
/*
 vector table relocation and key-protected application interrupt and reset
 control registers behind an axi4-lite slave.
 assumes: the processor core, reset controller and interrupt controller sit
 outside and take the outputs below; byte order comes from a strap level.
 the strap is caught once, three cycles after reset release, so it must be
 settled before reset ends; rstn doubles as the warm reset of the request.
*/
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "vtrc_defs.svh"
module vtrc_top
   import vtrc_pkg::*;
(
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rstn,
   // strap for byte order, from a pin
   input  wire logic         byte_order_strap,
   // axi4-lite write channels
   input  wire logic [31:0]  awaddr,
   input  wire logic         awvalid,
   output logic              awready,
   input  wire logic [31:0]  wdata,
   input  wire logic [3:0]   wstrb,
   input  wire logic         wvalid,
   output logic              wready,
   output logic [1:0]        bresp,
   output logic              bvalid,
   input  wire logic         bready,
   // axi4-lite read channels
   input  wire logic [31:0]  araddr,
   input  wire logic         arvalid,
   output logic              arready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   output logic              rvalid,
   input  wire logic         rready,
   // vector table location
   output logic [31:0]       vector_table_base,
   // priority split to the interrupt controller
   output logic [2:0]        priority_split_select,
   output logic [7:0]        preempt_mask,
   // reset and clear requests
   output logic              system_reset_request,
   output logic              active_state_clear,
   output logic              core_reset_trigger
);
   import vtrc_pkg::*;

   // all state of the slice in one word
   typedef struct packed {
      logic        sync1;
      logic        sync2;
      logic [1:0]  order_wait;
      logic        byte_order;
      logic        region;
      logic [21:0] offset;
      logic [2:0]  split;
      logic        sysreq;
      logic        clract;
      logic        corerst;
   } vtrc_regs_t;

   vtrc_regs_t r_ff;
   vtrc_regs_t nxt_r;
   vtrc_reg_if rif ();

   // merge byte lanes of a write into an old word
   function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[i*8 +: 8] = new_w[i*8 +: 8];
      return res;
   endfunction

   // pre-emption bits of an eight-bit priority for a split code
   function automatic logic [7:0] split_mask(input logic [2:0] code);
      return 8'hFE << code;
   endfunction

   // true when a word address selects the relocation register
   function automatic logic sel_vtr(input logic [3:0] addr);
      return addr == `VTRC_VTR_ADDR;
   endfunction

   // true when a word address selects the control register
   function automatic logic sel_arc(input logic [3:0] addr);
      return addr == `VTRC_ARC_ADDR;
   endfunction

   // current register images
   logic [31:0] vtr_word;
   logic [31:0] arc_word;
   logic [31:0] wr_vtr;
   logic [31:0] wr_arc;
   logic        key_ok;
   logic        wr_vtr_en;
   logic        wr_arc_en;

   always_comb
   begin
      vtr_word = 32'h0000_0000;
      vtr_word[`VTRC_VTR_REGION_BIT] = r_ff.region;
      vtr_word[`VTRC_VTR_OFF_HI:`VTRC_VTR_OFF_LO] = r_ff.offset;
      arc_word = 32'h0000_0000;
      arc_word[`VTRC_ARC_KEY_HI:`VTRC_ARC_KEY_LO] = `VTRC_ARC_RD_KEY;
      arc_word[`VTRC_ARC_ORDER_BIT] = r_ff.byte_order;
      arc_word[`VTRC_ARC_SPLIT_HI:`VTRC_ARC_SPLIT_LO] = r_ff.split;
      arc_word[`VTRC_ARC_SYSREQ_BIT] = r_ff.sysreq;
      arc_word[`VTRC_ARC_CLRACT_BIT] = r_ff.clract;
      arc_word[`VTRC_ARC_CORERST_BIT] = r_ff.corerst;
   end

   // address decode; an unmapped address is answered with an error by the front end
   assign rif.hit_rd  = sel_vtr(rif.req.rd_addr) || sel_arc(rif.req.rd_addr);
   assign rif.hit_wr  = sel_vtr(rif.req.wr_addr) || sel_arc(rif.req.wr_addr);
   assign rif.rd_data = sel_arc(rif.req.rd_addr) ? arc_word : vtr_word;

   // write images; key checked on bits 31:16 of the merged word
   assign wr_vtr = lane_merge(vtr_word, rif.req.wr_data, rif.req.wr_strb);
   assign wr_arc = lane_merge(32'h0000_0000, rif.req.wr_data, rif.req.wr_strb);
   assign key_ok = (wr_arc[`VTRC_ARC_KEY_HI:`VTRC_ARC_KEY_LO] == `VTRC_ARC_WR_KEY);

   // per-register write strobes; a control write without the key is dropped whole
   assign wr_vtr_en = rif.req.wr_en && sel_vtr(rif.req.wr_addr);
   assign wr_arc_en = rif.req.wr_en && sel_arc(rif.req.wr_addr) && key_ok;

   // register updates
   always_comb
   begin
      nxt_r       = r_ff;
      nxt_r.sync1 = byte_order_strap;
      nxt_r.sync2 = r_ff.sync1;
      // the strap settles through both flops, then is caught once
      if (r_ff.order_wait != `VTRC_ORDER_DONE)
      begin
         nxt_r.order_wait = r_ff.order_wait + 2'h1;
         if (r_ff.order_wait == `VTRC_ORDER_CATCH)
            nxt_r.byte_order = r_ff.sync2;
      end
      // one-shot clears fall after one cycle
      nxt_r.clract  = 1'b0;
      nxt_r.corerst = 1'b0;
      // a relocation write merges the strobed lanes into the old image
      if (wr_vtr_en)
      begin
         nxt_r.region = wr_vtr[`VTRC_VTR_REGION_BIT];
         nxt_r.offset = wr_vtr[`VTRC_VTR_OFF_HI:`VTRC_VTR_OFF_LO];
      end
      if (wr_arc_en)
      begin
         if (rif.req.wr_strb[1])
            nxt_r.split = wr_arc[`VTRC_ARC_SPLIT_HI:`VTRC_ARC_SPLIT_LO];
         if (wr_arc[`VTRC_ARC_SYSREQ_BIT])
            nxt_r.sysreq = 1'b1;
         if (wr_arc[`VTRC_ARC_CLRACT_BIT])
            nxt_r.clract = 1'b1;
         if (wr_arc[`VTRC_ARC_CORERST_BIT])
            nxt_r.corerst = 1'b1;
      end
   end

   // state register; the warm reset on rstn clears the reset request
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         r_ff       <= '0;
         r_ff.split <= `VTRC_SPLIT_RESET;
      end
      else
         r_ff <= nxt_r;
   end

   // outputs; the offset is used as written, keeping the table aligned is up to software
   assign vector_table_base     = (r_ff.region ? `VTRC_SRAM_BASE : `VTRC_CODE_BASE)
                                  + {3'h0, r_ff.offset, 7'h00};
   assign priority_split_select = r_ff.split;
   assign preempt_mask          = split_mask(r_ff.split);
   assign system_reset_request  = r_ff.sysreq;
   assign active_state_clear    = r_ff.clract;
   assign core_reset_trigger    = r_ff.corerst;

   // bus front end
   vtrc_axil_front u_front (
      .clock   (clock),
      .rstn    (rstn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .rif     (rif)
   );
endmodule

// File: shared/vtrc_defs.svh
/*
 holds offsets, field positions, reset values and fixed patterns of the vector
 table and reset control register slice; assumes a 32-bit register bus.
*/
`ifndef VTRC_DEFS_SVH
`define VTRC_DEFS_SVH

`define VTRC_VTR_ADDR        4'h0
`define VTRC_ARC_ADDR        4'h4
`define VTRC_ADDR_W          4
`define VTRC_VTR_RESET       32'h0000_0000
`define VTRC_VTR_REGION_BIT  29
`define VTRC_VTR_OFF_HI      28
`define VTRC_VTR_OFF_LO      7
`define VTRC_ARC_KEY_HI      31
`define VTRC_ARC_KEY_LO      16
`define VTRC_ARC_WR_KEY      16'h05FA
`define VTRC_ARC_RD_KEY      16'hFA05
`define VTRC_ARC_ORDER_BIT   15
`define VTRC_ARC_SPLIT_HI    10
`define VTRC_ARC_SPLIT_LO    8
`define VTRC_ARC_SYSREQ_BIT  2
`define VTRC_ARC_CLRACT_BIT  1
`define VTRC_ARC_CORERST_BIT 0
`define VTRC_SPLIT_RESET     3'h0
`define VTRC_ORDER_CATCH     2'h2
`define VTRC_ORDER_DONE      2'h3
`define VTRC_CODE_BASE       32'h0000_0000
`define VTRC_SRAM_BASE       32'h2000_0000
`define VTRC_RESP_OKAY       2'h0
`define VTRC_RESP_SLVERR     2'h2

`endif

// File: shared/vtrc_pkg.sv
/*
 holds the types shared by the register slice and its bus front end;
 assumes the constants header is on the include path.
*/
package vtrc_pkg;
   typedef enum logic [1:0] {
      VTRC_IDLE = 2'b00,
      VTRC_BRSP = 2'b01,
      VTRC_RRSP = 2'b10
   } vtrc_state_t;

   typedef struct packed {
      logic        wr_en;
      logic [3:0]  wr_addr;
      logic [31:0] wr_data;
      logic [3:0]  wr_strb;
      logic        rd_en;
      logic [3:0]  rd_addr;
   } vtrc_req_t;
endpackage

// File: shared/vtrc_reg_if.sv
/*
 carries decoded register accesses from the bus front end to the register
 file; assumes one clock domain and single-cycle strobes.
*/
`timescale 1ns/1ps
interface vtrc_reg_if;
   import vtrc_pkg::*;
   vtrc_req_t   req;      // one-cycle access strobes with address and data
   logic [31:0] rd_data;  // combinational read data for req.rd_addr
   logic        hit_wr;   // write address is mapped
   logic        hit_rd;   // read address is mapped
   modport front (output req, input rd_data, input hit_wr, input hit_rd);
   modport regs  (input req, output rd_data, output hit_wr, output hit_rd);
endinterface

// File: core/vtrc_axil_front.sv
/*
 axi4-lite slave front end: takes write address and data in either order,
 then answers; one access at a time, read or write, writes served first.
 assumes the master keeps valid and payload until taken.
*/
`timescale 1ns/1ps
`include "vtrc_defs.svh"
module vtrc_axil_front
   import vtrc_pkg::*;
(
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rstn,
   // write address and data
   input  wire logic [31:0]  awaddr,
   input  wire logic         awvalid,
   output logic              awready,
   input  wire logic [31:0]  wdata,
   input  wire logic [3:0]   wstrb,
   input  wire logic         wvalid,
   output logic              wready,
   // write response
   output logic [1:0]        bresp,
   output logic              bvalid,
   input  wire logic         bready,
   // read address and data
   input  wire logic [31:0]  araddr,
   input  wire logic         arvalid,
   output logic              arready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   output logic              rvalid,
   input  wire logic         rready,
   // register side
   vtrc_reg_if.front         rif
);
   import vtrc_pkg::*;

   typedef struct packed {
      vtrc_state_t st;
      logic        aw_held;
      logic        w_held;
      logic [3:0]  aw;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic [1:0]  bresp;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } vtrc_front_t;

   vtrc_front_t st_ff;
   vtrc_front_t nxt_st;

   // ready while idle and that channel not yet captured; read ready also needs no write captured or offered
   assign awready = (st_ff.st == VTRC_IDLE) && !st_ff.aw_held;
   assign wready  = (st_ff.st == VTRC_IDLE) && !st_ff.w_held;
   assign arready = (st_ff.st == VTRC_IDLE) && !st_ff.aw_held && !st_ff.w_held && !awvalid && !wvalid;
   assign bvalid  = (st_ff.st == VTRC_BRSP);
   assign rvalid  = (st_ff.st == VTRC_RRSP);
   assign bresp   = st_ff.bresp;
   assign rresp   = st_ff.rresp;
   assign rdata   = st_ff.rdata;

   // capture, access strobe, response sequencing
   always_comb
   begin
      nxt_st          = st_ff;
      rif.req         = '0;
      rif.req.wr_addr = st_ff.aw;
      rif.req.wr_data = st_ff.wd;
      rif.req.wr_strb = st_ff.ws;
      rif.req.rd_addr = araddr[3:0];
      unique case (st_ff.st)
         VTRC_IDLE:
         begin
            if (awvalid && awready)
            begin
               nxt_st.aw_held = 1'b1;
               nxt_st.aw      = awaddr[3:0];
            end
            if (wvalid && wready)
            begin
               nxt_st.w_held = 1'b1;
               nxt_st.wd     = wdata;
               nxt_st.ws     = wstrb;
            end
            if (st_ff.aw_held && st_ff.w_held)
            begin
               rif.req.wr_en  = 1'b1;   // one-cycle write strobe
               nxt_st.bresp   = rif.hit_wr ? `VTRC_RESP_OKAY : `VTRC_RESP_SLVERR;
               nxt_st.aw_held = 1'b0;
               nxt_st.w_held  = 1'b0;
               nxt_st.st      = VTRC_BRSP;
            end
            else if (arvalid && arready)
            begin
               rif.req.rd_en = 1'b1;
               nxt_st.rdata  = rif.hit_rd ? rif.rd_data : 32'h0000_0000;
               nxt_st.rresp  = rif.hit_rd ? `VTRC_RESP_OKAY : `VTRC_RESP_SLVERR;
               nxt_st.st     = VTRC_RRSP;
            end
         end
         VTRC_BRSP:
         begin
            if (bready)
               nxt_st.st = VTRC_IDLE;
         end
         VTRC_RRSP:
         begin
            if (rready)
               nxt_st.st = VTRC_IDLE;
         end
         default:
         begin
            nxt_st.st = VTRC_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
endmodule

// File: verif/vtrc_checker.sv
/*
 assertion checker for the vector table and reset control slice;
 assumes it is bound to vtrc_top and sees only the ports it names.
*/
`timescale 1ns/1ps
`include "vtrc_defs.svh"
module vtrc_checker
(
   // clock and reset
   input wire logic        clock,
   input wire logic        rstn,
   // bus channels
   input wire logic [31:0] wdata,
   input wire logic        bvalid,
   input wire logic [31:0] araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   // block outputs
   input wire logic [31:0] vector_table_base,
   input wire logic [2:0]  priority_split_select,
   input wire logic [7:0]  preempt_mask,
   input wire logic        system_reset_request,
   input wire logic        active_state_clear,
   input wire logic        core_reset_trigger
);
   logic rd_ctl_ff;

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   // remembers whether the read in flight targets the control register
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         rd_ctl_ff <= 1'b0;
      else if (arvalid && arready)
         rd_ctl_ff <= (araddr[3:0] == `VTRC_ARC_ADDR);
   end

   // register contents, outputs and their causes
   a_read_key: assert property (rvalid && rresp == `VTRC_RESP_OKAY && rd_ctl_ff |->
      rdata[31:16] == `VTRC_ARC_RD_KEY && rdata[14:11] == 4'h0 && rdata[7:3] == 5'h00)
      else $error("control read shows wrong key or reserved bits");
   a_reloc_resv: assert property (rvalid && rresp == `VTRC_RESP_OKAY && !rd_ctl_ff |->
      rdata[31:30] == 2'h0 && rdata[6:0] == 7'h00) else $error("relocation read reserved bits set");
   a_base_align: assert property (vector_table_base[31:30] == 2'h0 && vector_table_base[6:0] == 7'h00)
      else $error("table base outside region or misaligned");
   a_base_write: assert property ($changed(vector_table_base) |-> $rose(bvalid))
      else $error("table base moved without a write");
   a_mask_split: assert property (preempt_mask == ~(8'hFF >> (3'h7 - priority_split_select)))
      else $error("pre-emption mask does not follow split code");
   a_split_write: assert property ($changed(priority_split_select) |-> $rose(bvalid))
      else $error("split code moved without a write");
   a_sysreq_key: assert property ($rose(system_reset_request) |->
      $rose(bvalid) && $past(wdata[31:16], 2) == `VTRC_ARC_WR_KEY) else $error("reset request without keyed write");
   a_sysreq_hold: assert property (system_reset_request |=> system_reset_request)
      else $error("reset request dropped before reset");
   a_clr_pulse: assert property (active_state_clear |=> !active_state_clear)
      else $error("active clear longer than one cycle");
   a_core_pulse: assert property (core_reset_trigger |=> !core_reset_trigger)
      else $error("core reset longer than one cycle");
endmodule

bind vtrc_top vtrc_checker u_chk (.clock, .rstn, .wdata, .bvalid, .araddr, .arvalid, .arready, .rdata, .rresp,
   .rvalid, .vector_table_base, .priority_split_select, .preempt_mask, .system_reset_request, .active_state_clear,
   .core_reset_trigger);

// File: verif/tb_top.sv
/*
 self-checking bench for the vector table and reset control slice;
 assumes the checker is bound to vtrc_top and a 50 MHz clock.
*/
`timescale 1ns/1ps
`include "vtrc_defs.svh"
module tb_top;
   import vtrc_pkg::*;
   localparam logic [31:0] wkey = {`VTRC_ARC_WR_KEY, 16'h0000};
   localparam logic [31:0] rkey = {`VTRC_ARC_RD_KEY, 16'h0000};
   logic        clock, rstn, byte_order_strap, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        system_reset_request, active_state_clear, core_reset_trigger;
   logic [31:0] awaddr, wdata, araddr, rdata, vector_table_base;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [2:0]  priority_split_select;
   logic [7:0]  preempt_mask;
   int          num_errors, n_compared, n_clr, n_core;

   vtrc_top DUT (.clock, .rstn, .byte_order_strap, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .vector_table_base,
      .priority_split_select, .preempt_mask, .system_reset_request, .active_state_clear, .core_reset_trigger);

   // clock
   always #10 clock = ~clock;

   // counts one-cycle clear and reset pulses
   always @(posedge clock)
   begin
      if (active_state_clear === 1'b1)
         n_clr++;
      if (core_reset_trigger === 1'b1)
         n_core++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one write, both channels offered together, response checked
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      int n;
      n = 0;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1 && n < 100);
      chk({30'h0, bvalid === 1'b1 ? bresp : 2'bxx}, {30'h0, er});
      bready <= 1'b0;
      @(posedge clock);
   endtask

   // one read, data and response checked
   task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
         if (arvalid && arready)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1 && n < 100);
      chk({30'h0, rvalid === 1'b1 ? rresp : 2'bxx}, {30'h0, er});
      chk(rdata, ed);
      rready <= 1'b0;
      @(posedge clock);
   endtask

   task automatic t_reset_values;
      chk(vector_table_base, `VTRC_CODE_BASE);
      chk({24'h0, preempt_mask}, 32'h0000_00FE);
      rd(`VTRC_VTR_ADDR, `VTRC_VTR_RESET, `VTRC_RESP_OKAY);
      rd(`VTRC_ARC_ADDR, rkey, `VTRC_RESP_OKAY);
   endtask

   task automatic t_relocation;
      wr(`VTRC_VTR_ADDR, 32'hFFFF_FFFF, 4'hF, `VTRC_RESP_OKAY);
      rd(`VTRC_VTR_ADDR, 32'h3FFF_FF80, `VTRC_RESP_OKAY);
      chk(vector_table_base, `VTRC_SRAM_BASE + 32'h1FFF_FF80);
      wr(`VTRC_VTR_ADDR, 32'h2000_0100, 4'hF, `VTRC_RESP_OKAY);
      chk(vector_table_base, `VTRC_SRAM_BASE + 32'h0000_0100);
      wr(`VTRC_VTR_ADDR, 32'h0000_0080, 4'hF, `VTRC_RESP_OKAY);
      chk(vector_table_base, `VTRC_CODE_BASE + 32'h0000_0080);
      wr(`VTRC_VTR_ADDR, 32'hFF00_0000, 4'h8, `VTRC_RESP_OKAY);
      rd(`VTRC_VTR_ADDR, 32'h3F00_0080, `VTRC_RESP_OKAY);
      chk(vector_table_base, `VTRC_SRAM_BASE + 32'h1F00_0080);
   endtask

   task automatic t_split_codes;
      for (int i = 0; i < 8; i++)
      begin
         wr(`VTRC_ARC_ADDR, wkey | (i << 8), 4'hF, `VTRC_RESP_OKAY);
         chk({29'h0, priority_split_select}, i);
         chk({24'h0, preempt_mask}, {24'h0, ~(8'hFF >> (7 - i))});
         rd(`VTRC_ARC_ADDR, rkey | (i << 8), `VTRC_RESP_OKAY);
      end
      wr(`VTRC_ARC_ADDR, 32'h0000_0200, 4'hF, `VTRC_RESP_OKAY);
      wr(`VTRC_ARC_ADDR, 32'h05FB_0100, 4'hF, `VTRC_RESP_OKAY);
      chk({29'h0, priority_split_select}, 32'h7);
      wr(`VTRC_ARC_ADDR, wkey, 4'hF, `VTRC_RESP_OKAY);
      wr(`VTRC_ARC_ADDR, wkey | 32'h0000_0500, 4'hD, `VTRC_RESP_OKAY);
      chk({29'h0, priority_split_select}, 32'h0);
   endtask

   task automatic t_pulses;
      int c0, k0;
      c0 = n_clr;
      k0 = n_core;
      wr(`VTRC_ARC_ADDR, wkey | 32'h2, 4'hF, `VTRC_RESP_OKAY);
      wr(`VTRC_ARC_ADDR, wkey | 32'h1, 4'hF, `VTRC_RESP_OKAY);
      wr(`VTRC_ARC_ADDR, wkey, 4'hF, `VTRC_RESP_OKAY);
      wr(`VTRC_ARC_ADDR, 32'h0000_0003, 4'hF, `VTRC_RESP_OKAY);
      rd(`VTRC_ARC_ADDR, rkey, `VTRC_RESP_OKAY);
      chk(32'(n_clr - c0), 32'h1);
      chk(32'(n_core - k0), 32'h1);
   endtask

   task automatic t_unmapped;
      wr(32'h0000_0008, 32'hFFFF_FFFF, 4'hF, `VTRC_RESP_SLVERR);
      rd(32'h0000_000C, 32'h0, `VTRC_RESP_SLVERR);
      rd(`VTRC_VTR_ADDR, 32'h3F00_0080, `VTRC_RESP_OKAY);
   endtask

   task automatic t_sysreq;
      wr(`VTRC_ARC_ADDR, wkey | 32'h4, 4'hF, `VTRC_RESP_OKAY);
      repeat (5) @(posedge clock);
      chk({31'h0, system_reset_request}, 32'h1);
      rd(`VTRC_ARC_ADDR, rkey | 32'h4, `VTRC_RESP_OKAY);
      byte_order_strap <= 1'b1;
      rstn             <= 1'b0;
      repeat (3) @(posedge clock);
      chk({31'h0, system_reset_request}, 32'h0);
      rstn <= 1'b1;
      repeat (6) @(posedge clock);
      rd(`VTRC_ARC_ADDR, rkey | 32'h8000, `VTRC_RESP_OKAY);
      rd(`VTRC_VTR_ADDR, `VTRC_VTR_RESET, `VTRC_RESP_OKAY);
   endtask

   task automatic tally_and_finish;
      if (num_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // watchdog against a hung handshake
   initial
   begin
      repeat (5000) @(posedge clock);
      num_errors++;
      tally_and_finish;
   end

   // reset, then the scenarios in turn
   initial
   begin
      {clock, rstn, byte_order_strap, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
      {awaddr, wdata, araddr, wstrb} = 100'h0;
      {num_errors, n_compared, n_clr, n_core} = 128'h0;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      repeat (6) @(posedge clock);
      t_reset_values;
      t_relocation;
      t_split_codes;
      t_pulses;
      t_unmapped;
      t_sysreq;
      tally_and_finish;
   end
endmodule
